// file: rtl/lpfa_top.sv
// Contract
// - Hold 17-bit linear pointer across three bytes.
// - Post-increment port uses pointer, then increments.
// - Post-increment read returns byte before advancing.
// - Post-increment write delivers byte before advancing.
// - Byte and word post-increment ports behave identically.
// - Word port sits just before byte post-increment port.
// - Plain byte port addresses flash through pointer.
// - Plain port read returns byte, no increment.
// - Plain port write delivers byte, pointer unchanged.
// - Add port adds two's complement byte to pointer.
// - Add operand is sign-extended: 7f,80,ff.
`timescale 1ns/1ns
`include "lpfa_defs.svh"

module lpfa_top #(
   parameter int MEM_TIMEOUT_CYC = `LPFA_MEM_TIMEOUT_CYC
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire lpfa_pkg::lpfa_ahb_req_t i_ahb,
   input wire logic [31:0] i_hwdata,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire lpfa_pkg::lpfa_mem_rsp_t i_mem_rsp,
   output lpfa_pkg::lpfa_mem_req_t o_mem_req,
   output logic o_mem_timeout
);
   import lpfa_pkg::*;

   // ========================================================================
   // Declarations.
   lpfa_state_t state_reg;
   logic [11:0] addr_reg;
   logic write_reg;
   logic pending_reg;
   logic [31:0] hrdata_reg;
   logic [15:0] cnt_reg;
   logic timeout_reg;
   logic [16:0] pointer;
   lpfa_ptr_op_t ptr_op;
   logic [7:0] ptr_operand;
   logic [1:0] ptr_sel;
   logic mem_start;
   logic mem_done;
   logic [7:0] mem_rdata;
   logic addr_phase;
   logic is_flash_port;
   logic is_inc_port;

   if (MEM_TIMEOUT_CYC < 1 || MEM_TIMEOUT_CYC > 65535) begin : g_bad_timeout
      $error("lpfa_top: MEM_TIMEOUT_CYC out of range");
   end

   // Classifies a register offset as one of the pointed flash ports.
   function automatic logic flash_port(input logic [11:0] a);
      flash_port = (a == `LPFA_OFS_WORD_PORT) || (a == `LPFA_OFS_BYTE_INC) || (a == `LPFA_OFS_BYTE_PLAIN);
   endfunction

   // Word port and byte post-increment port decode to one function.
   function automatic logic inc_port(input logic [11:0] a);
      inc_port = (a == `LPFA_OFS_WORD_PORT) || (a == `LPFA_OFS_BYTE_INC);
   endfunction

   // ========================================================================
   // Address phase capture; only accepted while the slave is ready.
   assign addr_phase = i_ahb.hsel && i_ahb.hready && i_ahb.htrans[1] && o_hreadyout;

   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         pending_reg <= 1'b0;
         addr_reg <= 12'h000;
         write_reg <= 1'b0;
      end else if (addr_phase) begin
         pending_reg <= 1'b1;
         addr_reg <= i_ahb.haddr[11:0];
         write_reg <= i_ahb.hwrite;
      end else if (state_reg == LPFA_DONE || (state_reg == LPFA_IDLE && !is_flash_port)) begin
         // An array access keeps its transfer pending until DONE, so the data
         // phase stays stretched while the array is still working.
         pending_reg <= 1'b0;
      end
   end

   assign is_flash_port = flash_port(addr_reg);
   assign is_inc_port = inc_port(addr_reg);

   // ========================================================================
   // Sequencer: a flash access stretches the data phase until the array
   // answers or the timeout fires, so the pointer moves only after data was returned or delivered, or the access timed out.
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         state_reg <= LPFA_IDLE;
      end else begin
         case (state_reg)
            LPFA_IDLE: begin
               if (pending_reg && is_flash_port) begin
                  state_reg <= LPFA_MEM_WAIT;
               end
            end
            LPFA_MEM_WAIT: begin
               if (mem_done || timeout_reg) begin
                  state_reg <= LPFA_DONE;
               end
            end
            LPFA_DONE: state_reg <= LPFA_IDLE;
            default: state_reg <= LPFA_IDLE;
         endcase
      end
   end

   assign mem_start = (state_reg == LPFA_IDLE) && pending_reg && is_flash_port;

   // Guard against an array that never answers; the bus would hang forever.
   // The limit trades a lost access for a live bus; the sticky flag records it.
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         cnt_reg <= 16'h0000;
         timeout_reg <= 1'b0;
      end else if (state_reg == LPFA_MEM_WAIT) begin
         cnt_reg <= cnt_reg + 16'h0001;
         timeout_reg <= (cnt_reg >= 16'(MEM_TIMEOUT_CYC - 1));
      end else begin
         cnt_reg <= 16'h0000;
         timeout_reg <= 1'b0;
      end
   end

   // Sticky timeout flag, visible in status; cleared only by reset.
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         o_mem_timeout <= 1'b0;
      end else if (timeout_reg && state_reg == LPFA_MEM_WAIT) begin
         o_mem_timeout <= 1'b1;
      end
   end

   // ========================================================================
   // Pointer operation select.
   // Register writes act in their single wait state, so each one acts once.
   always_comb begin
      ptr_op = LPFA_PTR_HOLD;
      ptr_operand = i_hwdata[7:0];
      ptr_sel = 2'h0;
      if (state_reg == LPFA_DONE && is_inc_port) begin
         ptr_op = LPFA_PTR_INC;
      end else if (state_reg == LPFA_IDLE && pending_reg && write_reg) begin
         case (addr_reg)
            `LPFA_OFS_ADD: ptr_op = LPFA_PTR_ADD;
            `LPFA_OFS_PTR_LOW: begin
               ptr_op = LPFA_PTR_LOAD;
               ptr_sel = 2'h0;
            end
            `LPFA_OFS_PTR_MID: begin
               ptr_op = LPFA_PTR_LOAD;
               ptr_sel = 2'h1;
            end
            `LPFA_OFS_PTR_HIGH: begin
               ptr_op = LPFA_PTR_LOAD;
               ptr_sel = 2'h2;
            end
            default: ptr_op = LPFA_PTR_HOLD;
         endcase
      end
   end

   lpfa_pointer #(
      .PTR_WIDTH(`LPFA_PTR_WIDTH)
   ) u_pointer (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_op(ptr_op),
      .i_operand(ptr_operand),
      .i_byte_sel(ptr_sel),
      .o_pointer(pointer)
   );

   // The pointer value at start is the flash address for every port.
   lpfa_flash_port u_flash (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_start(mem_start),
      .i_write(write_reg),
      .i_addr(pointer),
      .i_wdata(i_hwdata[7:0]),
      .i_mem_rsp(i_mem_rsp),
      .o_mem_req(o_mem_req),
      .o_done(mem_done),
      .o_rdata(mem_rdata)
   );

   // ========================================================================
   // Read data register; loaded for the cycle in which hreadyout rises.
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (state_reg == LPFA_MEM_WAIT && mem_done) begin
         hrdata_reg <= {24'h000000, mem_rdata};
      end else if (state_reg == LPFA_MEM_WAIT && timeout_reg) begin
         hrdata_reg <= 32'h0000_0000;
      end else if (state_reg == LPFA_IDLE && pending_reg && !write_reg) begin
         case (addr_reg)
            `LPFA_OFS_PTR_LOW: hrdata_reg <= {24'h000000, pointer[7:0]};
            `LPFA_OFS_PTR_MID: hrdata_reg <= {24'h000000, pointer[15:8]};
            `LPFA_OFS_PTR_HIGH: hrdata_reg <= {31'h0, pointer[16]};
            `LPFA_OFS_STATUS: hrdata_reg <= {30'h0, o_mem_timeout, 1'b0};
            default: hrdata_reg <= 32'h0000_0000;
         endcase
      end
   end

   // Register accesses finish after one wait state, because their pending flag
   // clears at the first idle edge; array accesses hold the data phase until
   // DONE, so read data is in place before the pointer moves.
   assign o_hreadyout = !pending_reg || (state_reg == LPFA_DONE);
   assign o_hrdata = hrdata_reg;
   assign o_hresp = 1'b0;

   // ========================================================================
   // Checks. Properties watch only what this block drives: the bus master
   // and the array are the far side. Each label names what it guards.
   // Post-increment ports move the pointer by exactly one, after the access.
   ptr_inc_after_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_reg == LPFA_DONE && is_inc_port) |=> (pointer == $past(pointer) + 17'h00001))
      else $error("pointer did not advance after post-increment access");
   // The plain port leaves the pointer where it was.
   plain_hold_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_reg == LPFA_DONE && !is_inc_port) |=> (pointer == $past(pointer)))
      else $error("plain port moved the pointer");
   // The array is addressed with the pointer as it stood at the start.
   mem_addr_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      mem_start |=> (o_mem_req.req && o_mem_req.addr == $past(pointer)))
      else $error("flash request not at pointer");
   // The pointer must not move while the array is still working.
   inc_order_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_reg == LPFA_MEM_WAIT) |-> (pointer == $past(pointer)))
      else $error("pointer moved before the flash answered");
   // Signed add: bit 7 of the operand fills all upper pointer bits.
   add_signed_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (ptr_op == LPFA_PTR_ADD) |=> (pointer == $past(pointer) + {{9{$past(ptr_operand[7])}}, $past(ptr_operand)}))
      else $error("signed add wrong");
   // A write hands the data-phase byte to the array unchanged.
   write_data_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (mem_start && write_reg) |=> (o_mem_req.write && o_mem_req.wdata == $past(i_hwdata[7:0])))
      else $error("write byte not delivered");
   // The word port advances the pointer just like the byte post-increment port.
   word_same_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_reg == LPFA_DONE && addr_reg == `LPFA_OFS_WORD_PORT) |=> (pointer == $past(pointer) + 17'h00001))
      else $error("word port not post-incrementing");
   // Read data reaches the bus in the cycle that ends the data phase.
   read_return_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_reg == LPFA_MEM_WAIT && mem_done) |=> (hrdata_reg[7:0] == $past(mem_rdata) && o_hreadyout))
      else $error("read byte not returned");
   // Every array access ends, by answer or by timeout, in bounded time.
   ready_bound_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (mem_start) |-> ##[1:300] o_hreadyout)
      else $error("flash access did not finish");
   // Register accesses take exactly one wait state.
   reg_one_wait_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (pending_reg && state_reg == LPFA_IDLE && !is_flash_port) |-> (!o_hreadyout ##1 o_hreadyout))
      else $error("register access wait state wrong");
   // The data phase stays stretched for the whole array access.
   wait_low_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_reg == LPFA_MEM_WAIT) |-> !o_hreadyout)
      else $error("data phase ended before the array answered");
   // An increment past the top of the map wraps to zero.
   wrap_inc_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_reg == LPFA_DONE && is_inc_port && pointer == 17'h1ffff) |=> (pointer == 17'h00000))
      else $error("pointer did not wrap");
   // A low byte load places the written byte in the pointer.
   load_byte_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (ptr_op == LPFA_PTR_LOAD && ptr_sel == 2'h0) |=> (pointer[7:0] == $past(ptr_operand)))
      else $error("pointer low byte not loaded");
   // A request stands unchanged until the array acknowledges it.
   hold_req_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (o_mem_req.req && !i_mem_rsp.ack && !mem_start) |=> (o_mem_req.req && $stable(o_mem_req.addr)))
      else $error("flash request dropped early");
   // A timed-out access returns zero rather than stale data.
   timeout_zero_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (state_reg == LPFA_MEM_WAIT && timeout_reg && !mem_done) |=> (o_hrdata == 32'h0000_0000))
      else $error("timed-out read returned stale data");
   // The timeout flag stays set once raised.
   timeout_sticky_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      o_mem_timeout |=> o_mem_timeout)
      else $error("timeout flag cleared");
   // A register read never moves the pointer.
   reg_read_hold_a: assert property (@(posedge i_clock) disable iff (!i_resetn)
      (pending_reg && state_reg == LPFA_IDLE && !write_reg && !is_flash_port) |=> (pointer == $past(pointer)))
      else $error("register read moved the pointer");

   // ========================================================================
   // Cover points for the main scenarios.
   cov_inc_c: cover property (@(posedge i_clock) state_reg == LPFA_DONE && is_inc_port);
   cov_plain_c: cover property (@(posedge i_clock) state_reg == LPFA_DONE && !is_inc_port);
   cov_add_c: cover property (@(posedge i_clock) ptr_op == LPFA_PTR_ADD && ptr_operand[7]);
   cov_timeout_c: cover property (@(posedge i_clock) state_reg == LPFA_MEM_WAIT && timeout_reg);
   cov_word_c: cover property (@(posedge i_clock) state_reg == LPFA_DONE && addr_reg == `LPFA_OFS_WORD_PORT);

endmodule // lpfa_top

// file: rtl/lpfa_defs.svh
`ifndef LPFA_DEFS_SVH
`define LPFA_DEFS_SVH

// ==========================================================================
// Register byte addresses on the AHB-Lite slave (each one aligned word).
`define LPFA_OFS_PTR_LOW 12'h000
`define LPFA_OFS_PTR_MID 12'h004
`define LPFA_OFS_PTR_HIGH 12'h008
`define LPFA_OFS_WORD_PORT 12'h00c
`define LPFA_OFS_BYTE_INC 12'h010
`define LPFA_OFS_BYTE_PLAIN 12'h014
`define LPFA_OFS_ADD 12'h018
`define LPFA_OFS_STATUS 12'h01c

// ==========================================================================
// Field layout and reset values.
`define LPFA_PTR_WIDTH 17
`define LPFA_PTR_RESET 17'h00000
`define LPFA_STATUS_BUSY_BIT 0

// ==========================================================================
// Timing: flash answer timeout, in ns, and derived cycles at 20 ns.
`define LPFA_CLK_PERIOD_NS 20
`define LPFA_MEM_TIMEOUT_NS 2000
`define LPFA_MEM_TIMEOUT_CYC (`LPFA_MEM_TIMEOUT_NS / `LPFA_CLK_PERIOD_NS)

`endif

// file: rtl/lpfa_pkg.sv
package lpfa_pkg;

   // =======================================================================
   // Types shared by the slave, the pointer and the flash port.
   typedef struct packed {
      logic [1:0] htrans;
      logic [31:0] haddr;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
      logic hready;
   } lpfa_ahb_req_t;

   typedef struct packed {
      logic req;
      logic write;
      logic [16:0] addr;
      logic [7:0] wdata;
   } lpfa_mem_req_t;

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
   } lpfa_mem_rsp_t;

   typedef enum logic [1:0] {
      LPFA_PTR_HOLD,
      LPFA_PTR_INC,
      LPFA_PTR_ADD,
      LPFA_PTR_LOAD
   } lpfa_ptr_op_t;

   typedef enum {
      LPFA_IDLE,
      LPFA_MEM_WAIT,
      LPFA_DONE
   } lpfa_state_t;

endpackage

// file: rtl/lpfa_pointer.sv
`timescale 1ns/1ns
`include "lpfa_defs.svh"

// Linear pointer register with increment, signed add and byte loads.
module lpfa_pointer #(
   parameter int PTR_WIDTH = `LPFA_PTR_WIDTH
) (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire lpfa_pkg::lpfa_ptr_op_t i_op,
   input wire logic [7:0] i_operand,
   input wire logic [1:0] i_byte_sel,
   output logic [PTR_WIDTH-1:0] o_pointer
);
   import lpfa_pkg::*;

   logic [PTR_WIDTH-1:0] pointer_reg;

   // ========================================================================
   // Elaboration check.
   if (PTR_WIDTH < 17 || PTR_WIDTH > 24) begin : g_bad_width
      $error("lpfa_pointer: PTR_WIDTH out of range");
   end

   // Sign extension keeps a negative add moving the pointer downward.
   function automatic logic [PTR_WIDTH-1:0] sext8(input logic [7:0] v);
      sext8 = {{(PTR_WIDTH-8){v[7]}}, v};
   endfunction

   // ========================================================================
   // Pointer update; all arithmetic wraps silently at the pointer width.
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         pointer_reg <= PTR_WIDTH'(`LPFA_PTR_RESET);
      end else begin
         case (i_op)
            LPFA_PTR_INC: pointer_reg <= pointer_reg + PTR_WIDTH'(1);
            LPFA_PTR_ADD: pointer_reg <= pointer_reg + sext8(i_operand);
            LPFA_PTR_LOAD: begin
               case (i_byte_sel)
                  2'h0: pointer_reg[7:0] <= i_operand;
                  2'h1: pointer_reg[15:8] <= i_operand;
                  default: pointer_reg[PTR_WIDTH-1:16] <= i_operand[PTR_WIDTH-17:0];
               endcase
            end
            default: pointer_reg <= pointer_reg;
         endcase
      end
   end

   assign o_pointer = pointer_reg;

endmodule // lpfa_pointer

// file: rtl/lpfa_flash_port.sv
`timescale 1ns/1ns
`include "lpfa_defs.svh"

// Single outstanding request toward the flash array, held until acknowledged.
module lpfa_flash_port (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_start,
   input wire logic i_write,
   input wire logic [16:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire lpfa_pkg::lpfa_mem_rsp_t i_mem_rsp,
   output lpfa_pkg::lpfa_mem_req_t o_mem_req,
   output logic o_done,
   output logic [7:0] o_rdata
);
   import lpfa_pkg::*;

   lpfa_mem_req_t req_reg;
   logic done_reg;
   logic [7:0] rdata_reg;

   // ========================================================================
   // Request stands from start until the array acknowledges it.
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         req_reg <= '0;
      end else if (i_start) begin
         req_reg <= '{req: 1'b1, write: i_write, addr: i_addr, wdata: i_wdata};
      end else if (i_mem_rsp.ack) begin
         req_reg.req <= 1'b0;
      end
   end

   // Read data is captured on the acknowledge so it cannot change afterwards.
   always_ff @(posedge i_clock) begin
      if (!i_resetn) begin
         done_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end else begin
         done_reg <= req_reg.req && i_mem_rsp.ack;
         if (req_reg.req && i_mem_rsp.ack && !req_reg.write) begin
            rdata_reg <= i_mem_rsp.rdata;
         end
      end
   end

   assign o_mem_req = req_reg;
   assign o_done = done_reg;
   assign o_rdata = rdata_reg;

endmodule // lpfa_flash_port

// file: verification/lpfa_flash_model.sv
`timescale 1ns/1ns

// =====================================================================
// Flash array stand-in: answers one request at a time after a delay.
module lpfa_flash_model (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic [3:0] i_delay,
   input wire lpfa_pkg::lpfa_mem_req_t i_mem_req,
   output lpfa_pkg::lpfa_mem_rsp_t o_mem_rsp
);
   import lpfa_pkg::*;
   logic [7:0] mem_reg [0:131071];
   logic [3:0] wait_reg;
   logic rest_reg;
   logic ack_reg;
   logic [7:0] data_reg;

   // Each byte holds a value derived from its address, so a wrong address shows.
   initial begin
      for (int a = 0; a < 131072; a++) begin
         mem_reg[a] = a[7:0] ^ a[15:8] ^ {7'h0, a[16]} ^ 8'h5a;
      end
   end

   // Delay of 4'hf never answers; one idle cycle follows each answer so a request
   // still up in the cycle after the acknowledge is not served twice.
   always @(posedge i_clock) begin
      if (!i_resetn) begin
         wait_reg <= 4'h0;
         rest_reg <= 1'b0;
         ack_reg <= 1'b0;
         data_reg <= 8'h00;
      end else begin
         ack_reg <= 1'b0;
         rest_reg <= 1'b0;
         if (!i_mem_req.req || rest_reg) begin
            wait_reg <= 4'h0;
         end else if (i_delay != 4'hf && wait_reg >= i_delay) begin
            ack_reg <= 1'b1;
            rest_reg <= 1'b1;
            wait_reg <= 4'h0;
            data_reg <= mem_reg[i_mem_req.addr];
            if (i_mem_req.write) begin
               mem_reg[i_mem_req.addr] <= i_mem_req.wdata;
            end
         end else if (wait_reg != 4'he) begin
            wait_reg <= wait_reg + 4'h1;
         end
      end
   end

   // Read data is only valid with the acknowledge; otherwise it shows the inverse.
   assign o_mem_rsp = {ack_reg, ack_reg ? data_reg : ~data_reg};
endmodule // lpfa_flash_model

// file: verification/test_linear_pointer_flash_access.sv
`timescale 1ns/1ns
`include "lpfa_defs.svh"

module test_linear_pointer_flash_access;
   import lpfa_pkg::*;
   logic i_clock;
   logic i_resetn;
   logic [1:0] h_trans;
   logic [31:0] h_addr;
   logic h_write;
   logic [31:0] h_wdata;
   logic [3:0] mem_delay;
   lpfa_ahb_req_t ahb;
   lpfa_mem_req_t mem_req;
   lpfa_mem_rsp_t mem_rsp;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic mem_timeout;
   logic [31:0] rd;
   int n_errors;
   int total_checks;
   logic [7:0] add_op [3] = '{8'hff, 8'h7f, 8'h80};
   logic [16:0] add_exp [3] = '{17'h1ffff, 17'h0007e, 17'h1fffe};

   // =====================================================================
   // Design, flash stand-in and clock.
   // The bus has one slave, so its hready is the slave's own hreadyout.
   assign ahb = {h_trans, h_addr, h_write, 3'b010, 1'b1, hreadyout};

   lpfa_top #(.MEM_TIMEOUT_CYC(16)) uut (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_ahb(ahb),
      .i_hwdata(h_wdata),
      .o_hrdata(hrdata),
      .o_hreadyout(hreadyout),
      .o_hresp(hresp),
      .i_mem_rsp(mem_rsp),
      .o_mem_req(mem_req),
      .o_mem_timeout(mem_timeout)
   );

   lpfa_flash_model flash (
      .i_clock(i_clock),
      .i_resetn(i_resetn),
      .i_delay(mem_delay),
      .i_mem_req(mem_req),
      .o_mem_rsp(mem_rsp)
   );

   // Free-running 50 MHz clock.
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   // =====================================================================
   // Bus and checking tasks.
   // Verdict and end of run, shared by the main sequence and every timeout.
   task automatic stop_test;
      if (n_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("Error %s expected %h seen %h", nm, e, g);
         n_errors++;
      end
   endtask

   // Samples hready and read data mid-cycle, which is what the next edge sees.
   task automatic wait_ready(output logic [31:0] d);
      int n;
      logic r;
      n = 0;
      r = 1'b0;
      while (r !== 1'b1) begin
         @(negedge i_clock);
         r = hreadyout;
         d = hrdata;
         @(posedge i_clock);
         n++;
         if (n > 200) begin
            $display("Error hready expected 1 seen 0");
            n_errors++;
            stop_test();
         end
      end
   endtask

   // One single word transfer: address phase, then data phase.
   task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] wd, output logic [31:0] d);
      h_trans <= 2'b10;
      h_addr <= {20'h0, a};
      h_write <= w;
      wait_ready(d);
      h_trans <= 2'b00;
      h_wdata <= wd;
      wait_ready(d);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      bus(a, 1'b1, {24'h0, v}, rd);
   endtask

   task automatic rd_chk(input logic [11:0] a, input string nm, input logic [7:0] e);
      bus(a, 1'b0, 32'h0, rd);
      chk(nm, {24'h0, e}, rd);
   endtask

   task automatic set_ptr(input logic [16:0] p);
      wr(`LPFA_OFS_PTR_LOW, p[7:0]);
      wr(`LPFA_OFS_PTR_MID, p[15:8]);
      wr(`LPFA_OFS_PTR_HIGH, {7'h0, p[16]});
   endtask

   task automatic ptr_chk(input logic [16:0] e);
      logic [31:0] lo;
      logic [31:0] mi;
      logic [31:0] hi;
      bus(`LPFA_OFS_PTR_LOW, 1'b0, 32'h0, lo);
      bus(`LPFA_OFS_PTR_MID, 1'b0, 32'h0, mi);
      bus(`LPFA_OFS_PTR_HIGH, 1'b0, 32'h0, hi);
      chk("pointer", {15'h0, e}, {15'h0, hi[0], mi[7:0], lo[7:0]});
   endtask

   function automatic logic [7:0] pat(input logic [16:0] a);
      return a[7:0] ^ a[15:8] ^ {7'h0, a[16]} ^ 8'h5a;
   endfunction

   // =====================================================================
   // Main sequence.
   initial begin
      i_resetn = 1'b0;
      h_trans = 2'b00;
      h_addr = 32'h0;
      h_write = 1'b0;
      h_wdata = 32'h0;
      mem_delay = 4'h0;
      n_errors = 0;
      total_checks = 0;
      repeat (5) @(posedge i_clock);
      i_resetn <= 1'b1;
      @(posedge i_clock);
      ptr_chk(17'h00000);
      rd_chk(`LPFA_OFS_ADD, "add port read", 8'h00);
      rd_chk(12'h020, "unmapped read", 8'h00);
      chk("hresp", 32'h0, {31'h0, hresp});
      chk("timeout flag clear", 32'h0, {31'h0, mem_timeout});
      // Plain port near the top of the map leaves the pointer alone.
      set_ptr(17'h1fffe);
      ptr_chk(17'h1fffe);
      rd_chk(`LPFA_OFS_BYTE_PLAIN, "plain read", pat(17'h1fffe));
      rd_chk(`LPFA_OFS_BYTE_PLAIN, "plain reread", pat(17'h1fffe));
      ptr_chk(17'h1fffe);
      // Post-increment ports with a slow flash, running across the wrap.
      mem_delay <= 4'h5;
      rd_chk(`LPFA_OFS_BYTE_INC, "inc read", pat(17'h1fffe));
      ptr_chk(17'h1ffff);
      rd_chk(`LPFA_OFS_WORD_PORT, "word read", pat(17'h1ffff));
      ptr_chk(17'h00000);
      // A word access as two back-to-back transfers yields consecutive bytes.
      set_ptr(17'h00100);
      rd_chk(`LPFA_OFS_WORD_PORT, "pair first", pat(17'h00100));
      rd_chk(`LPFA_OFS_BYTE_INC, "pair second", pat(17'h00101));
      ptr_chk(17'h00102);
      // Writes through all three data ports, read back with the plain port.
      mem_delay <= 4'h0;
      set_ptr(17'h00200);
      wr(`LPFA_OFS_BYTE_INC, 8'ha5);
      wr(`LPFA_OFS_WORD_PORT, 8'h3c);
      wr(`LPFA_OFS_BYTE_PLAIN, 8'h77);
      ptr_chk(17'h00202);
      wr(`LPFA_OFS_ADD, 8'hfe);
      rd_chk(`LPFA_OFS_BYTE_PLAIN, "written inc", 8'ha5);
      wr(`LPFA_OFS_ADD, 8'h01);
      rd_chk(`LPFA_OFS_BYTE_PLAIN, "written word", 8'h3c);
      wr(`LPFA_OFS_ADD, 8'h01);
      rd_chk(`LPFA_OFS_BYTE_PLAIN, "written plain", 8'h77);
      // Signed add: the extreme operands, each crossing the wrap.
      set_ptr(17'h00000);
      for (int i = 0; i < 3; i++) begin
         wr(`LPFA_OFS_ADD, add_op[i]);
         ptr_chk(add_exp[i]);
      end
      // A flash that never answers ends the access with zero and a sticky flag.
      mem_delay <= 4'hf;
      set_ptr(17'h00300);
      rd_chk(`LPFA_OFS_BYTE_INC, "timeout read", 8'h00);
      chk("timeout flag", 32'h1, {31'h0, mem_timeout});
      bus(`LPFA_OFS_STATUS, 1'b0, 32'h0, rd);
      chk("status timeout", 32'h2, rd & 32'h2);
      ptr_chk(17'h00301);
      stop_test();
   end
endmodule // test_linear_pointer_flash_access
